// ---- chan_if.sv ----
`timescale 1ns/1ps
interface chan_if;
    logic pin_raw;   // Raw request pin, asynchronous
    logic filtered;  // Synchronised, off-filtered level, 1 = ON

    modport filt (input pin_raw, output filtered);
    modport top  (output pin_raw, input filtered);
endinterface : chan_if

// ---- safety_unit_model.sv ----
`timescale 1ns/1ps
module safety_unit_model (
    input  wire logic clk_sys_i,
    input  wire logic guard_open_i,     // Guard switch, 1 = open
    input  wire logic stuck_b_i,        // Wiring fault, line B stays ON
    input  wire logic monitor_i,        // Feedback from the drive
    output logic      request_a_o = 1'b1, // Request line A, 1 = ON
    output logic      request_b_o = 1'b1, // Request line B, 1 = ON
    output logic      fail_o = 1'b0       // Restart blocked
);
    logic guard_q = 1'b0; // Guard level one edge ago
    // Open guard drops line A, and line B unless stuck; closing checks the feedback
    always @(posedge clk_sys_i) begin
        guard_q <= guard_open_i;
        if (guard_open_i) begin
            {request_a_o, request_b_o} <= {1'b0, stuck_b_i};
        end else if (guard_q && monitor_i) begin
            {request_a_o, request_b_o, fail_o} <= 3'h6;
        end else if (guard_q) begin
            fail_o <= 1'b1;
        end
    end
endmodule : safety_unit_model

// ---- sto_checker.sv ----
`timescale 1ns/1ps
module sto_checker #(
    parameter int unsigned OFF_CYCLES  = sto_pkg::FILTER_CYCLES,
    parameter int unsigned SKEW_CYCLES = sto_pkg::SKEW_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic shutoff_request_a_i,
    input wire logic shutoff_request_b_i,
    input wire logic safety_connector_fitted_i,
    input wire logic servo_fault_req_i,
    input wire logic shutoff_monitor_out_o,
    input wire logic servo_fault_out_o,
    input wire logic brake_release_out_o,
    input wire logic dynamic_brake_o,
    input wire logic motor_current_en_o,
    input wire logic estop_status_bit_o,
    input wire logic input_timing_fault_o
);
    int off_a, off_b, next_off_a, next_off_b; // Pin OFF run lengths
    // Count consecutive OFF samples of each raw pin
    always_comb begin
        next_off_a = shutoff_request_a_i ? 0 : off_a + (off_a < 32'h7FFF_FFFF);
        next_off_b = shutoff_request_b_i ? 0 : off_b + (off_b < 32'h7FFF_FFFF);
    end
    // Register the run lengths
    always_ff @(posedge clk_sys_i) begin
        off_a <= next_off_a;
        off_b <= next_off_b;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // Both pins ON with the connector fitted
    sequence both_on_s;
        (shutoff_request_a_i && shutoff_request_b_i
         && safety_connector_fitted_i)[*6];
    endsequence
    AST_MON_OFF: assert property (
        both_on_s |=> !shutoff_monitor_out_o)
        else $error("monitor on with both requests on");
    AST_MON_ON: assert property (
        off_a > OFF_CYCLES + 8 && off_b > OFF_CYCLES + 8
        |-> shutoff_monitor_out_o)
        else $error("monitor off with both requests off");
    AST_ENTER_FILT: assert property (
        $rose(estop_status_bit_o) && safety_connector_fitted_i
        |-> $past(off_a, 2) >= OFF_CYCLES - 2
            || $past(off_b, 2) >= OFF_CYCLES - 2)
        else $error("shut-off entered on a short pulse");
    AST_GATE: assert property (
        estop_status_bit_o |-> !servo_fault_out_o
            && !brake_release_out_o && !motor_current_en_o)
        else $error("drive output active during shut-off");
    AST_PASS: assert property (!estop_status_bit_o
        |-> servo_fault_out_o == $past(servo_fault_req_i))
        else $error("fault output not following request");
    AST_DYN: assert property (
        dynamic_brake_o |-> estop_status_bit_o)
        else $error("dynamic brake outside shut-off");
    AST_MON_EST: assert property (
        shutoff_monitor_out_o |-> estop_status_bit_o)
        else $error("monitor on without shut-off");
    AST_SKEW: assert property ($rose(input_timing_fault_o)
        |-> off_a >= SKEW_CYCLES || off_b >= SKEW_CYCLES)
        else $error("timing fault raised too early");
endmodule : sto_checker

bind sto_monitor sto_checker #(.OFF_CYCLES(OFF_CYCLES),
    .SKEW_CYCLES(SKEW_CYCLES)) i_sto_checker (.clk_sys_i, .srst_i,
    .shutoff_request_a_i, .shutoff_request_b_i, .safety_connector_fitted_i,
    .servo_fault_req_i, .shutoff_monitor_out_o, .servo_fault_out_o,
    .brake_release_out_o, .dynamic_brake_o, .motor_current_en_o,
    .estop_status_bit_o, .input_timing_fault_o);

// ---- sto_filter.sv ----
`timescale 1ns/1ps
module sto_filter #(
    parameter int unsigned OFF_CYCLES = sto_pkg::FILTER_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    chan_if.filt      ch
);
    logic        sync_1;       // First synchroniser stage
    logic        sync_2;       // Second synchroniser stage
    logic [31:0] off_count;    // Consecutive off cycles
    logic        level;        // Filtered level
    logic [31:0] next_off_count;
    logic        next_level;

    // Two-flop synchroniser on the pin
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
        end else begin
            sync_1 <= ch.pin_raw; // RULE_13
            sync_2 <= sync_1;     // RULE_13
        end
    end

    // Off must outlast the filter time, on is taken at once
    always_comb begin
        next_off_count = off_count;
        next_level     = level;
        if (sync_2) begin
            next_off_count = 32'h0000_0000;
            next_level     = 1'b1;
        end else if (off_count >= OFF_CYCLES) begin
            next_level     = 1'b0; // RULE_09
        end else begin
            next_off_count = off_count + 32'h0000_0001;
        end
    end

    // Filter state, starts as OFF
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            off_count <= 32'h0000_0000;
            level     <= 1'b0;
        end else begin
            off_count <= next_off_count;
            level     <= next_level;
        end
    end

    assign ch.filtered = level;
endmodule : sto_filter

// ---- sto_monitor.sv ----
// Operation
// RULE_01: Monitor ON only when both requests OFF
// RULE_02: Monitor follows inputs within 20 ms
// RULE_03: Dynamic brake on shut-off when selected
// RULE_04: No servo fault output during shut-off
// RULE_05: Missing connector forces both inputs OFF
// RULE_06: Safety unit resets only on monitor ON
// RULE_07: Safety unit blocks restart if monitor OFF
// RULE_08: Both request states readable by software
// RULE_09: Off pulses of 0.5 ms ignored
// RULE_10: Ten second input skew raises fault
// RULE_11: Emergency stop status bit set during shut-off
// RULE_12: Brake release dropped at once on shut-off
// RULE_13: Request inputs synchronised before use
// RULE_14: Shut-off active when either request OFF
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module sto_monitor #(
    parameter int unsigned OFF_CYCLES  = sto_pkg::FILTER_CYCLES,
    parameter int unsigned SKEW_CYCLES = sto_pkg::SKEW_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // Safety pins
    input  wire logic        shutoff_request_a_i,
    input  wire logic        shutoff_request_b_i,
    input  wire logic        safety_connector_fitted_i,
    // Requests from drive logic, same clock
    input  wire logic        servo_fault_req_i,
    input  wire logic        brake_release_req_i,
    input  wire logic        motor_current_req_i,
    // Drive outputs
    output logic             shutoff_monitor_out_o,
    output logic             servo_fault_out_o,
    output logic             brake_release_out_o,
    output logic             dynamic_brake_o,
    output logic             motor_current_en_o,
    output logic             estop_status_bit_o,
    output logic             input_timing_fault_o,
    output logic             irq_o,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    chan_if chan [2] ();           // Two request channels
    logic [1:0]  req_filt;         // Filtered levels, 1 = ON
    logic        conn_s1;          // Connector synchroniser stage 1
    logic        conn_s2;          // Connector synchroniser stage 2

    assign chan[0].pin_raw = shutoff_request_a_i;
    assign chan[1].pin_raw = shutoff_request_b_i;

    // One filter per request channel
    for (genvar i = 0; i < 2; i++) begin : g_chan
        sto_filter #(
            .OFF_CYCLES (OFF_CYCLES)
        ) u_filter (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .ch        (chan[i])
        );
        assign req_filt[i] = chan[i].filtered;
    end

    // Connector presence synchroniser
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            conn_s1 <= 1'b0;
            conn_s2 <= 1'b0;
        end else begin
            conn_s1 <= safety_connector_fitted_i; // RULE_13
            conn_s2 <= conn_s1;
        end
    end

    // Effective request states and derived shut-off
    logic [1:0] req_eff;           // Requests after connector check
    logic       hard_shutoff_state;
    logic       both_off;
    assign req_eff            = conn_s2 ? req_filt : 2'h0; // RULE_05
    assign hard_shutoff_state = ~req_eff[0] | ~req_eff[1]; // RULE_14
    assign both_off           = ~req_eff[0] & ~req_eff[1]; // RULE_01

    // Registers
    logic [7:0]  ctrl;             // Control, stop method select
    logic [1:0]  irq_stat;         // Sticky events
    logic [1:0]  irq_mask;         // Event enables
    logic [31:0] skew_count;       // Cycles with requests unequal
    logic        shutoff_d;        // Delayed shut-off for edge
    logic [31:0] rdata;            // Registered read data
    logic        ack;              // Registered acknowledge
    logic [7:0]  next_ctrl;
    logic [1:0]  next_irq_stat;
    logic [1:0]  next_irq_mask;
    logic [31:0] next_skew_count;
    logic [31:0] next_rdata;
    logic        next_ack;
    logic        mon, fault_o, brk, dyn, cur, estop, irq;
    logic        next_mon, next_fault_o, next_brk, next_dyn;
    logic        next_cur, next_estop, next_irq;

    // Bus strobes, valid on the first request cycle only
    logic        bus_req;
    logic        wr_low;
    logic        skew_event;
    logic        enter_event;
    logic [1:0]  events;
    logic [31:0] status_word;
    assign bus_req     = wb_cyc_i & wb_stb_i & ~ack;
    assign wr_low      = bus_req & wb_we_i & wb_sel_i[0];
    assign skew_event  = (skew_count == SKEW_CYCLES - 32'h0000_0001)
                         & (req_eff[0] ^ req_eff[1]);
    assign enter_event = hard_shutoff_state & ~shutoff_d;
    assign events      = {enter_event, skew_event};

    // Status word: request view, shut-off and monitor state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[sto_pkg::STAT_REQ_A_BIT] = req_eff[0]; // RULE_08
        status_word[sto_pkg::STAT_REQ_B_BIT] = req_eff[1]; // RULE_08
        status_word[sto_pkg::STAT_HARD_BIT]  = hard_shutoff_state;
        status_word[sto_pkg::STAT_ESTOP_BIT] = hard_shutoff_state; // RULE_11
        status_word[sto_pkg::STAT_MON_BIT]   = mon;
        status_word[sto_pkg::STAT_CONN_BIT]  = conn_s2;
    end

    // Next-state logic for bus, events and outputs
    always_comb begin
        next_ctrl       = ctrl;
        next_irq_mask   = irq_mask;
        next_irq_stat   = irq_stat;
        next_rdata      = 32'h0000_0000;
        next_ack        = bus_req;
        next_skew_count = skew_count;
        // Skew timer runs while exactly one request is OFF
        if (req_eff[0] ^ req_eff[1]) begin
            if (skew_count < SKEW_CYCLES) begin
                next_skew_count = skew_count + 32'h0000_0001; // RULE_10
            end
        end else begin
            next_skew_count = 32'h0000_0000;
        end
        // Register writes, one-to-clear on interrupt status
        if (wr_low) begin
            unique case (wb_adr_i)
                sto_pkg::CTRL_OFFSET:     next_ctrl = wb_dat_i[7:0];
                sto_pkg::IRQ_STAT_OFFSET: begin
                    next_irq_stat = irq_stat & ~wb_dat_i[1:0];
                end
                sto_pkg::IRQ_MASK_OFFSET: next_irq_mask = wb_dat_i[1:0];
                default:                  next_ctrl = ctrl;
            endcase
        end
        // Event set wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events; // RULE_10
        // Register reads, unmapped reads as zero
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                sto_pkg::CTRL_OFFSET:     next_rdata = {24'h0, ctrl};
                sto_pkg::STATUS_OFFSET:   next_rdata = status_word;
                sto_pkg::IRQ_STAT_OFFSET: next_rdata = {30'h0, irq_stat};
                sto_pkg::IRQ_MASK_OFFSET: next_rdata = {30'h0, irq_mask};
                default:                  next_rdata = 32'h0000_0000;
            endcase
        end
        // Output values, registered next edge
        next_mon     = both_off; // RULE_02
        next_fault_o = servo_fault_req_i & ~hard_shutoff_state; // RULE_04
        next_brk     = brake_release_req_i & ~hard_shutoff_state; // RULE_12
        next_dyn     = hard_shutoff_state
                       & ctrl[sto_pkg::CTRL_STOP_BIT]; // RULE_03
        next_cur     = motor_current_req_i & ~hard_shutoff_state; // RULE_05
        next_estop   = hard_shutoff_state; // RULE_11
        next_irq     = |(next_irq_stat & next_irq_mask);
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl       <= sto_pkg::CTRL_RESET;
            irq_stat   <= sto_pkg::IRQ_RESET;
            irq_mask   <= sto_pkg::IRQ_RESET;
            skew_count <= 32'h0000_0000;
            shutoff_d  <= 1'b1;
            rdata      <= 32'h0000_0000;
            ack        <= 1'b0;
            mon        <= 1'b1;
            fault_o    <= 1'b0;
            brk        <= 1'b0;
            dyn        <= 1'b0;
            cur        <= 1'b0;
            estop      <= 1'b1;
            irq        <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            skew_count <= next_skew_count;
            shutoff_d  <= hard_shutoff_state;
            rdata      <= next_rdata;
            ack        <= next_ack;
            mon        <= next_mon; // RULE_01
            fault_o    <= next_fault_o;
            brk        <= next_brk;
            dyn        <= next_dyn;
            cur        <= next_cur;
            estop      <= next_estop;
            irq        <= next_irq;
        end
    end

    // Outputs straight from flip-flops
    assign shutoff_monitor_out_o = mon;
    assign servo_fault_out_o     = fault_o;
    assign brake_release_out_o   = brk;
    assign dynamic_brake_o       = dyn;
    assign motor_current_en_o    = cur;
    assign estop_status_bit_o    = estop;
    assign input_timing_fault_o  = irq_stat[sto_pkg::IRQ_FAULT_BIT];
    assign irq_o                 = irq;
    assign wb_dat_o              = rdata;
    assign wb_ack_o              = ack;
endmodule : sto_monitor

// ---- sto_pkg.sv ----
package sto_pkg;
    // Clock period of clk_sys_i
    localparam int unsigned CLK_PERIOD_NS   = 5;
    // Longest off time that is still ignored
    localparam int unsigned FILTER_TIME_NS  = 500000;
    localparam int unsigned FILTER_CYCLES   = FILTER_TIME_NS / CLK_PERIOD_NS;
    // Longest monitor update delay (met by design, kept for reference)
    localparam int unsigned MONITOR_MAX_MS  = 20;
    // Allowed skew between the two request inputs
    localparam longint unsigned SKEW_TIME_MS = 10000;
    localparam longint unsigned CYC_PER_MS  = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SKEW_CYCLES     =
        32'(SKEW_TIME_MS * CYC_PER_MS);

    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET      = 4'h0;
    localparam logic [3:0] STATUS_OFFSET    = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFFSET  = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFFSET  = 4'hC;

    // Control register fields
    localparam int unsigned CTRL_STOP_BIT   = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Status register fields
    localparam int unsigned STAT_REQ_A_BIT  = 0;
    localparam int unsigned STAT_REQ_B_BIT  = 1;
    localparam int unsigned STAT_HARD_BIT   = 2;
    localparam int unsigned STAT_ESTOP_BIT  = 3;
    localparam int unsigned STAT_MON_BIT    = 4;
    localparam int unsigned STAT_CONN_BIT   = 5;

    // Interrupt fields
    localparam int unsigned IRQ_FAULT_BIT   = 0;
    localparam int unsigned IRQ_ENTER_BIT   = 1;
    localparam int unsigned IRQ_WIDTH       = 2;
    localparam logic [1:0]  IRQ_RESET       = 2'h0;
endpackage : sto_pkg

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        clk, srst, conn, f_req, b_req, c_req, cyc, stb, we;
    logic        guard, stuck, glitch, req_a, req_b, fail, mon, fault;
    logic        brake, dyn, cur, estop, tfault, irq, ack;
    logic [3:0]  adr, sel;
    logic [31:0] dat_i, dat_o, rd;
    int          errors, n_tests;
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sto_monitor #(.OFF_CYCLES(8), .SKEW_CYCLES(50)) i_sto_monitor (
        .clk_sys_i(clk), .srst_i(srst), .shutoff_request_a_i(req_a & ~glitch),
        .shutoff_request_b_i(req_b), .safety_connector_fitted_i(conn),
        .servo_fault_req_i(f_req), .brake_release_req_i(b_req),
        .motor_current_req_i(c_req), .shutoff_monitor_out_o(mon),
        .servo_fault_out_o(fault), .brake_release_out_o(brake),
        .dynamic_brake_o(dyn), .motor_current_en_o(cur),
        .estop_status_bit_o(estop), .input_timing_fault_o(tfault),
        .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack_o(ack));
    safety_unit_model i_safety_unit_model (.clk_sys_i(clk),
        .guard_open_i(guard), .stuck_b_i(stuck), .monitor_i(mon),
        .request_a_o(req_a), .request_b_o(req_b), .fail_o(fail));
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cycles(int n);
        repeat (n) @(posedge clk);
    endtask : cycles
    // One classic bus cycle, held until ack
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        {cyc, stb, we, adr, dat_i} <= {2'h3, w, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        {cyc, stb} <= 2'h0;
        if (ack !== 1'b1) begin
            errors++;
            final_report();
        end
        @(posedge clk);
    endtask : wb
    task automatic t_regs;
        wb(0, sto_pkg::STATUS_OFFSET, 0);
        check("status", rd, 32'h23);
        wb(1, 4'h2, 32'hFF);
        wb(0, sto_pkg::CTRL_OFFSET, 0);
        check("ctrl", rd, 32'h0);
        wb(0, sto_pkg::IRQ_MASK_OFFSET, 0);
        check("mask", rd, 32'h0);
    endtask : t_regs
    task automatic t_glitch;
        glitch <= 1'b1;
        cycles(6);
        glitch <= 1'b0;
        cycles(10);
        wb(0, sto_pkg::IRQ_STAT_OFFSET, 0);
        check("glitch", {rd[1:0], estop}, 3'h0);
    endtask : t_glitch
    task automatic t_guard;
        wb(1, sto_pkg::CTRL_OFFSET, 1);
        wb(1, sto_pkg::IRQ_MASK_OFFSET, 2);
        {f_req, b_req, c_req, guard} <= 4'hF;
        cycles(30);
        check("outs", {mon, fault, brake, cur, dyn, estop, irq},
              7'h47);
        wb(0, sto_pkg::STATUS_OFFSET, 0);
        check("status_off", rd, 32'h3C);
        guard <= 1'b0;
        cycles(10);
        check("restart", {fail, mon, estop, fault, brake, cur},
              6'h07);
        wb(1, sto_pkg::IRQ_STAT_OFFSET, 2);
        cycles(2);
        check("irq_clr", irq, 1'b0);
    endtask : t_guard
    task automatic t_stuck;
        wb(1, sto_pkg::IRQ_MASK_OFFSET, 0);
        {stuck, guard} <= 2'h3;
        cycles(20);
        for (int n = 0; n < 200 && tfault !== 1'b1; n++) @(posedge clk);
        check("skew", {tfault, irq, mon}, 3'h4);
        if (tfault !== 1'b1) final_report();
        guard <= 1'b0;
        cycles(5);
        check("blocked", {fail, estop}, 2'h3);
        wb(1, sto_pkg::IRQ_MASK_OFFSET, 1);
        cycles(2);
        check("unmasked", irq, 1'b1);
        wb(1, sto_pkg::IRQ_STAT_OFFSET, 3);
        {stuck, guard} <= 2'h1;
        cycles(30);
        guard <= 1'b0;
        cycles(10);
        check("recover", {fail, estop, tfault}, 3'h0);
    endtask : t_stuck
    task automatic t_conn;
        wb(1, sto_pkg::CTRL_OFFSET, 0);
        conn <= 1'b0;
        cycles(20);
        wb(0, sto_pkg::STATUS_OFFSET, 0);
        check("noconn", {estop, cur, mon, rd[5], dyn},
              5'h14);
        conn <= 1'b1;
        cycles(20);
    endtask : t_conn
    // Main sequence
    initial begin
        {srst, conn, f_req, b_req, c_req, cyc, stb, we} = 8'hC0;
        {guard, stuck, glitch, adr, sel, dat_i} =
            {3'h0, 4'h0, 4'hF, 32'h0000_0000};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        cycles(10);
        t_regs();
        t_glitch();
        t_guard();
        t_stuck();
        t_conn();
        final_report();
    end
endmodule : testbench
